/* rtl/art_timer.sv */
// auto-reload 16-bit / dual 8-bit timer with capture, on the sfr port
`timescale 1ns/1ns
`include "art_map.svh"
module art_timer #(
    parameter int PRESCALE = `ART_SYSTEM_CLOCK_PRESCALE,
    parameter int RTC_DIVIDE = `ART_RTC_DIVIDE
) (
    // clock and reset
    mclk,
    sys_rst,
    // special function register port
    sfrReq,
    sfrRdData,
    // clock select and interrupt enable bits held in other registers
    highByteSysclkSelect,
    lowByteSysclkSelect,
    timerIrqEnable,
    // event sources
    rtcClockIn,
    comparator0In,
    // interrupt request and status
    timerIrq,
    countValue
);
    input wire logic mclk;
    input wire logic sys_rst;
    input wire art_pkg::art_sfr_req_t sfrReq;
    output logic [7:0] sfrRdData;
    input wire logic highByteSysclkSelect;
    input wire logic lowByteSysclkSelect;
    input wire logic timerIrqEnable;
    input wire logic rtcClockIn;
    input wire logic comparator0In;
    output logic timerIrq;
    output logic [15:0] countValue;

    localparam int PRE_W = $clog2(PRESCALE);
    localparam int RTC_W = $clog2(RTC_DIVIDE);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE - 1);
    localparam logic [RTC_W-1:0] RTC_LAST = RTC_W'(RTC_DIVIDE - 1);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    // dividers below two would collapse into the plain system clock path
    if (PRESCALE < 2) begin : g_bad_prescale
        $error("art_timer: PRESCALE must be at least 2");
    end
    if (RTC_DIVIDE < 2) begin : g_bad_rtc_divide
        $error("art_timer: RTC_DIVIDE must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////////
    // state

    art_pkg::art_ctrl_t ctrl_q;
    art_pkg::art_ctrl_t ctrl_d;
    logic [7:0] countLow_q;
    logic [7:0] countLow_d;
    logic [7:0] countHigh_q;
    logic [7:0] countHigh_d;
    logic [7:0] reloadLow_q;
    logic [7:0] reloadHigh_q;
    logic [PRE_W-1:0] preCnt_q;
    logic [RTC_W-1:0] rtcCnt_q;
    logic [7:0] rdData_q;
    logic irq_q;

    logic rtcEdge;
    logic cmpEdge;
    logic div12Tick;
    logic rtc8Tick;
    logic extTick;
    logic lowTick;
    logic highTick;
    logic lowInc;
    logic highInc;
    logic lowWrap;
    logic highWrap;
    logic fullWrap;
    logic captureStrobe;
    logic setHighFlag;
    logic setLowFlag;
    logic [7:0] ctrlWritten;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // one address compare used by every register
    function automatic logic hits(input art_pkg::art_sfr_req_t req, input logic [7:0] addr);
        hits = req.wrEn && (req.addr == addr);
    endfunction : hits

    // byte that is all ones wraps on the next increment
    function automatic logic atTop(input logic [7:0] value);
        atTop = (value == `ART_BYTE_ALL_ONES);
    endfunction : atTop

    ////////////////////////////////////////////////////////////////////////////
    // event synchronisers

    art_edge_sync u_rtc_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .levelIn(rtcClockIn),
        .risePulse(rtcEdge)
    );

    art_edge_sync u_cmp_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .levelIn(comparator0In),
        .risePulse(cmpEdge)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock dividers

    // free-running system clock prescaler, one enable pulse per period
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            preCnt_q <= '0;
        end else if (preCnt_q == PRE_LAST) begin
            preCnt_q <= '0;
        end else begin
            preCnt_q <= preCnt_q + PRE_W'(1);
        end
    end

    // counts synchronised rtc edges; the same pulse clocks and captures
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rtcCnt_q <= '0;
        end else if (rtcEdge) begin
            rtcCnt_q <= (rtcCnt_q == RTC_LAST) ? '0 : rtcCnt_q + RTC_W'(1);
        end
    end

    assign div12Tick = (preCnt_q == PRE_LAST);
    assign rtc8Tick = rtcEdge && (rtcCnt_q == RTC_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // count source selection

    // reserved code gives no ticks at all
    always_comb begin
        case (art_pkg::art_src_t'(ctrl_q.externalClockSelect))
            art_pkg::ART_SRC_DIV12: extTick = div12Tick;
            art_pkg::ART_SRC_RTC8: extTick = rtc8Tick;
            art_pkg::ART_SRC_CMP0: extTick = cmpEdge;
            art_pkg::ART_SRC_NONE: extTick = 1'b0;
            default: extTick = 1'b0;
        endcase
    end

    // the 16-bit count follows the low byte select
    assign lowTick = lowByteSysclkSelect | extTick;
    assign highTick = highByteSysclkSelect | extTick;

    ////////////////////////////////////////////////////////////////////////////
    // increment and overflow decode

    always_comb begin
        if (ctrl_q.dual8bitSelect) begin
            lowInc = lowTick;
            highInc = ctrl_q.runControl & highTick;
            lowWrap = lowInc & atTop(countLow_q);
            highWrap = highInc & atTop(countHigh_q);
            fullWrap = 1'b0;
        end else begin
            lowInc = ctrl_q.runControl & lowTick;
            lowWrap = lowInc & atTop(countLow_q);
            highInc = lowWrap;
            highWrap = highInc & atTop(countHigh_q);
            fullWrap = highWrap;
        end
    end

    // capture source: bit 1 of the external field, rtc when clear
    assign captureStrobe = ctrl_q.captureModeEnable
        & (ctrl_q.externalClockSelect[`ART_BIT_XCLK_HI] ? cmpEdge : rtc8Tick);

    assign setHighFlag = highWrap | captureStrobe;
    assign setLowFlag = lowWrap;

    ////////////////////////////////////////////////////////////////////////////
    // counter bytes

    // in 16-bit capture mode the reload bytes hold captures, so overflow wraps to zero
    always_comb begin
        countLow_d = countLow_q;
        if (hits(sfrReq, `ART_ADDR_COUNT_LOW)) begin
            countLow_d = sfrReq.wrData;
        end else if (lowWrap) begin
            if (ctrl_q.dual8bitSelect) begin
                countLow_d = reloadLow_q;
            end else if (fullWrap && !ctrl_q.captureModeEnable) begin
                countLow_d = reloadLow_q;
            end else begin
                countLow_d = `ART_RESET_BYTE;
            end
        end else if (lowInc) begin
            countLow_d = countLow_q + 8'h01;
        end
    end

    always_comb begin
        countHigh_d = countHigh_q;
        if (hits(sfrReq, `ART_ADDR_COUNT_HIGH)) begin
            countHigh_d = sfrReq.wrData;
        end else if (highWrap) begin
            if (ctrl_q.dual8bitSelect || !ctrl_q.captureModeEnable) begin
                countHigh_d = reloadHigh_q;
            end else begin
                countHigh_d = `ART_RESET_BYTE;
            end
        end else if (highInc) begin
            countHigh_d = countHigh_q + 8'h01;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            countLow_q <= `ART_RESET_BYTE;
            countHigh_q <= `ART_RESET_BYTE;
        end else begin
            countLow_q <= countLow_d;
            countHigh_q <= countHigh_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reload bytes

    // a capture in the same cycle as a software write wins, so no event is lost
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reloadLow_q <= `ART_RESET_BYTE;
            reloadHigh_q <= `ART_RESET_BYTE;
        end else if (captureStrobe) begin
            reloadLow_q <= countLow_q;
            reloadHigh_q <= countHigh_q;
        end else begin
            if (hits(sfrReq, `ART_ADDR_RELOAD_LOW)) begin
                reloadLow_q <= sfrReq.wrData;
            end
            if (hits(sfrReq, `ART_ADDR_RELOAD_HIGH)) begin
                reloadHigh_q <= sfrReq.wrData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register

    // byte write or single-bit write, then hardware sets on top
    always_comb begin
        ctrlWritten = ctrl_q;
        if (hits(sfrReq, `ART_ADDR_CTRL)) begin
            ctrlWritten = sfrReq.wrData;
        end else if (sfrReq.bitWrEn && (sfrReq.addr == `ART_ADDR_CTRL)) begin
            ctrlWritten[sfrReq.bitSel] = sfrReq.bitVal;
        end
        ctrl_d = art_pkg::art_ctrl_t'(ctrlWritten);
        // only software ever clears a flag; a set in the clear cycle wins
        ctrl_d.highOverflowFlag = ctrlWritten[`ART_BIT_HIGH_FLAG] | setHighFlag;
        ctrl_d.lowOverflowFlag = ctrlWritten[`ART_BIT_LOW_FLAG] | setLowFlag;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= art_pkg::art_ctrl_t'(`ART_RESET_CTRL);
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt request

    // level request follows the sticky flags, one cycle after a set
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= timerIrqEnable & (ctrl_q.highOverflowFlag
                | (ctrl_q.lowByteIrqEnable & ctrl_q.lowOverflowFlag));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data

    // registered read, one cycle after the read strobe; unmapped reads zero
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rdData_q <= `ART_RESET_BYTE;
        end else if (sfrReq.rdEn) begin
            case (sfrReq.addr)
                `ART_ADDR_CTRL: rdData_q <= ctrl_q;
                `ART_ADDR_COUNT_LOW: rdData_q <= countLow_q;
                `ART_ADDR_COUNT_HIGH: rdData_q <= countHigh_q;
                `ART_ADDR_RELOAD_LOW: rdData_q <= reloadLow_q;
                `ART_ADDR_RELOAD_HIGH: rdData_q <= reloadHigh_q;
                default: rdData_q <= `ART_RESET_BYTE;
            endcase
        end
    end

    assign sfrRdData = rdData_q;
    assign timerIrq = irq_q;
    assign countValue = {countHigh_q, countLow_q};

endmodule : art_timer

/* rtl/art_map.svh */
// offsets, field positions, reset values and timing counts of the auto-reload timer
`ifndef ART_MAP_SVH
`define ART_MAP_SVH

// register addresses on the special function register port
`define ART_ADDR_CTRL 8'hc8
`define ART_ADDR_RELOAD_LOW 8'hca
`define ART_ADDR_RELOAD_HIGH 8'hcb
`define ART_ADDR_COUNT_LOW 8'hcc
`define ART_ADDR_COUNT_HIGH 8'hcd

// control register bit positions
`define ART_BIT_HIGH_FLAG 7
`define ART_BIT_LOW_FLAG 6
`define ART_BIT_LOW_IRQ_EN 5
`define ART_BIT_CAPTURE_EN 4
`define ART_BIT_SPLIT 3
`define ART_BIT_RUN 2
`define ART_BIT_XCLK_HI 1
`define ART_BIT_XCLK_LO 0

// reset values
`define ART_RESET_CTRL 8'h00
`define ART_RESET_BYTE 8'h00
`define ART_BYTE_ALL_ONES 8'hff

// timing counts
`define ART_SYSTEM_CLOCK_PRESCALE 12
`define ART_RTC_DIVIDE 8

`endif

/* rtl/art_pkg.sv */
// types shared by the auto-reload timer files
package art_pkg;

    // control register fields, msb first as they sit in the byte
    typedef struct packed {
        logic highOverflowFlag;
        logic lowOverflowFlag;
        logic lowByteIrqEnable;
        logic captureModeEnable;
        logic dual8bitSelect;
        logic runControl;
        logic [1:0] externalClockSelect;
    } art_ctrl_t;

    // external clock source codes
    typedef enum logic [1:0] {
        ART_SRC_DIV12 = 2'b00,
        ART_SRC_RTC8 = 2'b01,
        ART_SRC_NONE = 2'b10,
        ART_SRC_CMP0 = 2'b11
    } art_src_t;

    // special function register access from the cpu side
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic bitWrEn;
        logic [7:0] addr;
        logic [7:0] wrData;
        logic [2:0] bitSel;
        logic bitVal;
    } art_sfr_req_t;

endpackage : art_pkg

/* rtl/art_edge_sync.sv */
// two-flop synchroniser with a one-cycle rising edge strobe
`timescale 1ns/1ns
module art_edge_sync (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // raw level from another clock or analog source
    input wire logic levelIn,
    // one-cycle strobe per rising edge
    output logic risePulse
);

    logic meta_q;
    logic sync_q;
    logic prev_q;

    // the first flop is read only by the second
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= levelIn;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // edge taken from the settled stages only, so one strobe per edge
    assign risePulse = sync_q & ~prev_q;

endmodule : art_edge_sync

/* verif/art_timer_props.sv */
// concurrent checks on the timer's register port, count and interrupt
`timescale 1ns/1ns
`include "art_map.svh"
module art_timer_props #(parameter int PRESCALE = 12, parameter int RTC_DIVIDE = 8) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // register port
    input wire art_pkg::art_sfr_req_t sfrReq,
    input wire logic [7:0] sfrRdData,
    // levels and results
    input wire logic lowByteSysclkSelect,
    input wire logic timerIrqEnable,
    input wire logic timerIrq,
    input wire logic [15:0] countValue
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [5:0] ctrlQ;
    logic anyWr;
    assign anyWr = sfrReq.wrEn | sfrReq.bitWrEn;
    ////////////////////////////////////////////////////////////////////////
    // shadow of software-owned control bits; flags left out, hardware sets them
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrlQ <= 6'h00;
        end else if (sfrReq.addr != `ART_ADDR_CTRL) begin
            ctrlQ <= ctrlQ;
        end else if (sfrReq.wrEn) begin
            ctrlQ <= sfrReq.wrData[5:0];
        end else if (sfrReq.bitWrEn && sfrReq.bitSel < 3'h6) begin
            ctrlQ[sfrReq.bitSel] <= sfrReq.bitVal;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // high byte left 0xff by counting, not by a write
    sequence s_hiWrap;
        $past(countValue[15:8]) == 8'hff && countValue[15:8] != 8'hff && !$past(anyWr);
    endsequence
    property p_hiIrq;
        s_hiWrap ##0 (timerIrqEnable && !anyWr) |=> timerIrq;
    endproperty
    a_hiIrq: assert property (p_hiIrq) else $error("no interrupt after high wrap");
    property p_cntInc;
        !ctrlQ[3] && ctrlQ[2] && lowByteSysclkSelect && !anyWr && countValue != 16'hffff
            |=> countValue == $past(countValue) + 16'h0001;
    endproperty
    a_cntInc: assert property (p_cntInc) else $error("count did not step by one");
    property p_stop;
        !ctrlQ[3] && !ctrlQ[2] && !anyWr |=> $stable(countValue);
    endproperty
    a_stop: assert property (p_stop) else $error("count moved while stopped");
    property p_hiHold;
        ctrlQ[3] && !ctrlQ[2] && !anyWr |=> $stable(countValue[15:8]);
    endproperty
    a_hiHold: assert property (p_hiHold) else $error("high counter ran without run");
    property p_irqOff;
        !timerIrqEnable |=> !timerIrq;
    endproperty
    a_irqOff: assert property (p_irqOff) else $error("interrupt while disabled");
    // sticky flags: with timerIrqEnable held, only a write may drop the request, and it shows two edges later
    property p_irqHold;
        timerIrq && timerIrqEnable && !anyWr && !$past(anyWr) |=> timerIrq;
    endproperty
    a_irqHold: assert property (p_irqHold) else $error("interrupt dropped by itself");
    property p_unmap;
        sfrReq.rdEn && !(sfrReq.addr inside {`ART_ADDR_CTRL,
            [`ART_ADDR_RELOAD_LOW:`ART_ADDR_COUNT_HIGH]}) |=> sfrRdData == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_ctrlRd;
        sfrReq.rdEn && sfrReq.addr == `ART_ADDR_CTRL && !anyWr
            |=> sfrRdData[5:0] == $past(ctrlQ);
    endproperty
    a_ctrlRd: assert property (p_ctrlRd) else $error("control readback wrong");
endmodule : art_timer_props
bind art_timer art_timer_props #(.PRESCALE(PRESCALE), .RTC_DIVIDE(RTC_DIVIDE))
    i_art_timer_props (.mclk(mclk), .sys_rst(sys_rst), .sfrReq(sfrReq),
    .sfrRdData(sfrRdData), .lowByteSysclkSelect(lowByteSysclkSelect),
    .timerIrqEnable(timerIrqEnable), .timerIrq(timerIrq), .countValue(countValue));

/* verif/art_rtc_model.sv */
// free-running rtc oscillator seen by the timer's event input
`timescale 1ns/1ns
module art_rtc_model #(
    parameter int HALF_NS = 50
) (
    // oscillator output
    output logic rtcClockIn
);
    // 100 ns period drifts against the 8 ns mclk, far slower than the count clock
    initial begin
        rtcClockIn = 1'b0;
        forever #HALF_NS rtcClockIn = ~rtcClockIn;
    end
endmodule : art_rtc_model

/* verif/auto_reload_timer_with_capture_tb_top.sv */
// self-checking bench for the auto-reload timer
`timescale 1ns/1ns
module auto_reload_timer_with_capture_tb_top;
    logic mclk;
    logic sys_rst;
    art_pkg::art_sfr_req_t sfrReq;
    logic [7:0] sfrRdData, rdv, v1;
    logic highByteSysclkSelect, lowByteSysclkSelect, timerIrqEnable;
    logic rtcClockIn, comparator0In, timerIrq;
    logic [15:0] countValue;
    int nErrors, samplesChecked;
    art_timer i_art_timer (.mclk, .sys_rst, .sfrReq, .sfrRdData, .highByteSysclkSelect,
        .lowByteSysclkSelect, .timerIrqEnable, .rtcClockIn, .comparator0In, .timerIrq,
        .countValue);
    art_rtc_model i_art_rtc_model (.rtcClockIn);
    ////////////////////////////////////////////////////////////////////////
    // 125 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic endSim;
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : endSim
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    // one strobe cycle; read data has landed once the second edge is past
    task automatic acc(input logic [2:0] k, input logic [7:0] a, input logic [7:0] d,
        input logic [2:0] s, input logic v);
        @(posedge mclk);
        sfrReq <= '{k[2], k[1], k[0], a, d, s, v};
        @(posedge mclk);
        sfrReq <= '0;
        #1;
        rdv = sfrRdData;
    endtask : acc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(3'h4, a, d, 3'h0, 1'b0);
    endtask : wr
    task automatic bw(input logic [2:0] s, input logic v);
        acc(3'h1, 8'hc8, 8'h00, s, v);
    endtask : bw
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        acc(3'h2, a, 8'h00, 3'h0, 1'b0);
        chk(rdv, exp);
    endtask : rdChk
    task automatic irqChk(input logic [7:0] exp);
        cyc(1);
        chk({7'h00, timerIrq}, exp);
    endtask : irqChk
    task automatic waitIrq;
        for (int i = 0; i < 600 && timerIrq !== 1'b1; i++) cyc(1);
        if (timerIrq !== 1'b1) begin
            nErrors++;
            $display("Error at %0t: got %h expected %h", $time, timerIrq, 1'b1);
            endSim();
        end
    endtask : waitIrq
    ////////////////////////////////////////////////////////////////////////
    // 16-bit wrap reloads both bytes, then a low wrap alone with low irq enabled
    task automatic tWide;
        @(posedge mclk);
        lowByteSysclkSelect <= 1'b1;
        timerIrqEnable <= 1'b1;
        wr(8'hca, 8'h34);
        wr(8'hcb, 8'h12);
        wr(8'hcc, 8'hfe);
        wr(8'hcd, 8'hff);
        wr(8'hc8, 8'h04);
        waitIrq();
        rdChk(8'hc8, 8'hc4);
        wr(8'hc8, 8'h00);
        irqChk(8'h00);
        rdChk(8'hcd, 8'h12);
        wr(8'hcc, 8'hfe);
        wr(8'hcd, 8'h00);
        wr(8'hc8, 8'h24);
        waitIrq();
        rdChk(8'hc8, 8'h64);
        wr(8'hc8, 8'h00);
    endtask : tWide
    // split mode; code 10 gives the low counter no ticks once system_clock is off
    task automatic tSplit;
        wr(8'hca, 8'hf0);
        wr(8'hcb, 8'h80);
        wr(8'hcc, 8'hfe);
        wr(8'hcd, 8'hfe);
        wr(8'hc8, 8'h0a);
        @(posedge mclk);
        highByteSysclkSelect <= 1'b1;
        repeat (4) @(posedge mclk);
        lowByteSysclkSelect <= 1'b0;
        rdChk(8'hcd, 8'hfe);
        rdChk(8'hcc, 8'hf3);
        rdChk(8'hc8, 8'h4a);
        chk({7'h00, timerIrq}, 8'h00);
        bw(3'h5, 1'b1);
        irqChk(8'h01);
        bw(3'h6, 1'b0);
        irqChk(8'h00);
        bw(3'h2, 1'b1);
        waitIrq();
        bw(3'h2, 1'b0);
        rdChk(8'hc8, 8'haa);
        wr(8'hc8, 8'h00);
    endtask : tSplit
    // each external code in turn; edge phases allow one tick either way
    task automatic tSource;
        int lens [4] = '{120, 1000, 200, 160};
        @(posedge mclk);
        highByteSysclkSelect <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            wr(8'hcc, 8'h00);
            wr(8'hc8, 8'h04 | 8'(k));
            for (int i = 0; i < lens[k]; i++) begin
                @(posedge mclk);
                comparator0In <= i[3];
            end
            wr(8'hc8, 8'h00);
            acc(3'h2, 8'hcc, 8'h00, 3'h0, 1'b0);
            if (k != 2 && rdv >= 8'h09 && rdv <= 8'h0b) rdv = 8'h0a;
            chk(rdv, (k == 2) ? 8'h00 : 8'h0a);
        end
    endtask : tSource
    // two comparator rises 40 cycles apart; a long high level captures once;
    // then rtc/8 captures, which land exactly 100 system clocks apart
    task automatic tCapture;
        @(posedge mclk);
        lowByteSysclkSelect <= 1'b1;
        comparator0In <= 1'b0;
        wr(8'hcc, 8'h00);
        wr(8'hc8, 8'h16);
        @(posedge mclk);
        comparator0In <= 1'b1;
        cyc(6);
        acc(3'h2, 8'hca, 8'h00, 3'h0, 1'b0);
        v1 = rdv;
        rdChk(8'hca, v1);
        repeat (10) @(posedge mclk);
        comparator0In <= 1'b0;
        repeat (20) @(posedge mclk);
        comparator0In <= 1'b1;
        cyc(6);
        acc(3'h2, 8'hca, 8'h00, 3'h0, 1'b0);
        chk(rdv - v1, 8'h28);
        rdChk(8'hc8, 8'h96);
        chk({7'h00, timerIrq}, 8'h01);
        wr(8'hc8, 8'h14);
        irqChk(8'h00);
        waitIrq();
        acc(3'h2, 8'hca, 8'h00, 3'h0, 1'b0);
        v1 = rdv;
        wr(8'hc8, 8'h14);
        irqChk(8'h00);
        waitIrq();
        acc(3'h2, 8'hca, 8'h00, 3'h0, 1'b0);
        chk(rdv - v1, 8'h64);
        wr(8'hc8, 8'h00);
    endtask : tCapture
    initial begin
        sys_rst = 1'b1;
        sfrReq = '0;
        highByteSysclkSelect = 1'b0;
        lowByteSysclkSelect = 1'b0;
        timerIrqEnable = 1'b0;
        comparator0In = 1'b0;
        nErrors = 0;
        samplesChecked = 0;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 6; i++) rdChk(8'hc8 + 8'(i), 8'h00);
        tWide();
        tSplit();
        tSource();
        tCapture();
        endSim();
    end
endmodule : auto_reload_timer_with_capture_tb_top
